// File: dv/srl_lock_recovery_tb.sv
// self-checking bench for the lock recovery block
`timescale 1ns/1ps
`include "srl_defs.svh"
module srl_lock_recovery_tb;
    import srl_pkg::*;
    localparam logic [23:0] LV = 24'h5a_c3e1;
    localparam logic [23:0] RV = 24'h3c_a571;
    localparam logic [3:0] LA = 4'h9;
    localparam logic [3:0] RA = 4'h6;
    localparam logic [2:0] SB = 3'h5;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, side_bit_en, want_lock;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, rx_left_aux, rx_right_aux, pins;
    logic rx_lock, rx_sample_stb, rx_compr_type, rx_audio_type, rx_block_start, rx_mute, rx_audio_stb;
    logic [23:0] rx_left, rx_right, rx_audio_left, rx_audio_right;
    logic rx_half, tx_half, rx_mclk_en, tx_mclk_en, side_frame_sync, clk_src;
    logic [1:0] bcnt;
    int n_fail, check_count, cyc;
    srl_src_model #(.LV(LV), .RV(RV), .LA(LA), .RA(RA), .SB(SB)) src_u (.clk_sys(clk_sys), .rst(rst),
        .want_lock(want_lock), .rx_lock(rx_lock), .rx_sample_stb(rx_sample_stb), .rx_left(rx_left),
        .rx_right(rx_right), .rx_left_aux(rx_left_aux), .rx_right_aux(rx_right_aux),
        .rx_compr_type(rx_compr_type), .rx_audio_type(rx_audio_type), .rx_block_start(rx_block_start));
    srl_lock_recovery dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_lock(rx_lock),
        .rx_sample_stb(rx_sample_stb), .rx_left(rx_left), .rx_right(rx_right), .rx_left_aux(rx_left_aux),
        .rx_right_aux(rx_right_aux), .rx_compr_type(rx_compr_type), .rx_audio_type(rx_audio_type),
        .rx_block_start(rx_block_start), .side_bit_en(side_bit_en), .rx_mute(rx_mute),
        .rx_audio_stb(rx_audio_stb), .rx_audio_left(rx_audio_left), .rx_audio_right(rx_audio_right),
        .receiver_clock_half_rate(rx_half), .transmitter_clock_half_rate(tx_half), .rx_mclk_en(rx_mclk_en),
        .tx_mclk_en(tx_mclk_en), .serial_data_output_pin(pins), .side_frame_sync(side_frame_sync),
        .side_stream_clock_source(clk_src));
    // ----------------------------------------
    // clock, bit clock pulses, timeout
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        bcnt <= bcnt + 2'h1;
        side_bit_en <= (bcnt == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic chk_bit(input logic g, input logic e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t bit got %b exp %b", $time, g, e);
        end
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t word got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_frame(input logic [255:0] g, input logic [255:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t frame got %h exp %h", $time, g, e);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic set_lock(input logic v, input int wait_n);
        @(posedge clk_sys);
        want_lock <= v;
        repeat (wait_n) @(posedge clk_sys);
        #1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        bus(0, `SRL_IDX_AUTO_RESUME, 0, 4'hf);
        chk_word(rd, 32'h0000_0000);
        bus(0, `SRL_IDX_LOCK_LOST, 0, 4'hf);
        chk_word(rd, 32'h0000_0000);
        bus(0, `SRL_IDX_RX_RATE, 0, 4'hf);
        chk_word(rd, 32'h0000_0001);
        bus(0, `SRL_IDX_SIDE_CTRL, 0, 4'hf);
        chk_word(rd, 32'h0000_0000);
        bus(1, `SRL_IDX_TX_RATE, 0, 4'h0);
        bus(0, `SRL_IDX_TX_RATE, 0, 4'hf);
        chk_word(rd, 32'h0000_0001);
        bus(1, 16'hf609, 32'h0000_001f, 4'hf);
        bus(0, 16'hf609, 0, 4'hf);
        chk_word(rd, 32'h0000_0000);
        chk_bit(rx_half, 1'b1);
        chk_bit(tx_half, 1'b1);
    endtask
    task automatic t_manual();
        set_lock(1, 40);
        chk_bit(rx_mute, 1'b0);
        chk_word({8'h0, rx_audio_left}, {8'h0, LV});
        chk_word({8'h0, rx_audio_right}, {8'h0, RV});
        set_lock(0, 1);
        chk_bit(rx_mute, 1'b1);
        bus(0, `SRL_IDX_LOCK_LOST, 0, 4'hf);
        chk_word(rd, 32'h0000_0001);
        set_lock(1, 40);
        chk_bit(rx_mute, 1'b1);
        // relocked but muted: no sample may reach the audio output
        repeat (16)
        begin
            @(posedge clk_sys);
            chk_bit(rx_audio_stb, 1'b0);
        end
        bus(0, `SRL_IDX_LOCK_LOST, 0, 4'hf);
        chk_word(rd, 32'h0000_0001);
        // restart by toggling the auto bit while still muted
        bus(1, `SRL_IDX_AUTO_RESUME, 32'h0000_0001, 4'hf);
        bus(1, `SRL_IDX_AUTO_RESUME, 32'h0000_0000, 4'hf);
        bus(0, `SRL_IDX_LOCK_LOST, 0, 4'hf);
        chk_word(rd, 32'h0000_0000);
        repeat (20) @(posedge clk_sys);
        #1 chk_bit(rx_mute, 1'b0);
    endtask
    task automatic t_auto();
        int n;
        bus(1, `SRL_IDX_AUTO_RESUME, 32'h0000_0001, 4'hf);
        set_lock(0, 4);
        chk_bit(rx_mute, 1'b1);
        bus(0, `SRL_IDX_LOCK_LOST, 0, 4'hf);
        chk_word(rd, 32'h0000_0001);
        set_lock(1, 40);
        chk_bit(rx_mute, 1'b0);
        // source gives one sample per 8 cycles, so two strobes in 16
        n = 0;
        repeat (16)
        begin
            @(posedge clk_sys);
            n += rx_audio_stb;
        end
        chk_word(n, 32'h0000_0002);
        bus(0, `SRL_IDX_LOCK_LOST, 0, 4'hf);
        chk_word(rd, 32'h0000_0000);
        bus(1, `SRL_IDX_AUTO_RESUME, 32'h0000_0000, 4'hf);
    endtask
    task automatic t_rates();
        logic a;
        bus(1, `SRL_IDX_RX_RATE, 0, 4'hf);
        bus(1, `SRL_IDX_TX_RATE, 0, 4'hf);
        #1 chk_bit(rx_half, 1'b0);
        chk_bit(tx_half, 1'b0);
        repeat (3)
        begin
            @(posedge clk_sys);
            #1 chk_bit(rx_mclk_en & tx_mclk_en, 1'b1);
        end
        bus(1, `SRL_IDX_RX_RATE, 1, 4'hf);
        bus(1, `SRL_IDX_TX_RATE, 1, 4'hf);
        #1 a = rx_mclk_en;
        repeat (3)
        begin
            @(posedge clk_sys);
            #1 chk_bit(rx_mclk_en, !a);
            chk_bit(tx_mclk_en, rx_mclk_en);
            a = rx_mclk_en;
        end
    endtask
    task automatic t_side();
        logic [255:0] exp_f, f;
        exp_f = {LV, 8'h0, 20'h0, LA, 8'h0, 22'h0, SB[2:1], 8'h0, 32'h0, RV, 8'h0, 20'h0, RA, 8'h0,
            32'h0, 23'h0, SB[0], 8'h0};
        for (int ln = 0; ln < 4; ln++)
        begin
            bus(1, `SRL_IDX_SIDE_CTRL, {27'h0, ln[0], 4'h1 << ln}, 4'hf);
            #1 chk_bit(clk_src, ln[0]);
            do @(posedge clk_sys); while (side_frame_sync !== 1'b1);
            chk_word({28'h0, pins & ~(4'h1 << ln)}, 32'h0000_0000);
            for (int i = 255; i >= 0; i--)
            begin
                f[i] = pins[ln];
                repeat (4) @(posedge clk_sys);
            end
            chk_frame(f, exp_f);
        end
        bus(1, `SRL_IDX_SIDE_CTRL, 32'h0000_0003, 4'hf);
        repeat (300) @(posedge clk_sys);
        #1 chk_bit(pins == 4'h0 && !side_frame_sync, 1'b1);
        bus(1, `SRL_IDX_SIDE_CTRL, 32'h0000_0000, 4'hf);
        repeat (300) @(posedge clk_sys);
        #1 chk_word({28'h0, pins}, 32'h0000_0000);
    endtask
    task automatic complete_run();
        $display("fails %0d checks %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        {rst, avs_read, avs_write, want_lock, side_bit_en} = 5'b10000;
        {avs_address, avs_writedata, avs_byteenable, bcnt} = '0;
        {n_fail, check_count, cyc} = '0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_manual();
        t_auto();
        t_rates();
        t_side();
        complete_run();
    end
endmodule

// File: dv/srl_src_model.sv
// behavioural s/pdif source feeding the receiver side of the lock recovery block
`timescale 1ns/1ps
module srl_src_model
    import srl_pkg::*;
#(
    parameter logic [23:0] LV = 24'h5a_c3e1,
    parameter logic [23:0] RV = 24'h3c_a571,
    parameter logic [3:0] LA = 4'h9,
    parameter logic [3:0] RA = 4'h6,
    parameter logic [2:0] SB = 3'h5
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic want_lock,
    output logic rx_lock,
    output logic rx_sample_stb,
    output logic [23:0] rx_left,
    output logic [23:0] rx_right,
    output logic [3:0] rx_left_aux,
    output logic [3:0] rx_right_aux,
    output logic rx_compr_type,
    output logic rx_audio_type,
    output logic rx_block_start
);
    logic [2:0] cnt_r;
    // ----------------------------------------
    // lock level and one sample every 8 cycles
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_lock <= 1'b0;
            cnt_r <= 3'h0;
            rx_sample_stb <= 1'b0;
        end
        else
        begin
            rx_lock <= want_lock;
            cnt_r <= cnt_r + 3'h1;
            rx_sample_stb <= want_lock && rx_lock && (cnt_r == 3'h7);
        end
    end
    // unlocked data is garbage, not a held copy
    assign rx_left = rx_lock ? LV : ~LV;
    assign rx_right = rx_lock ? RV : ~RV;
    assign rx_left_aux = rx_lock ? LA : ~LA;
    assign rx_right_aux = rx_lock ? RA : ~RA;
    assign {rx_compr_type, rx_audio_type, rx_block_start} = rx_lock ? SB : ~SB;
endmodule

// File: hw/srl_defs.svh
// register offsets, field positions, reset values and frame sizes of the lock recovery block
`ifndef SRL_DEFS_SVH
`define SRL_DEFS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define SRL_IDX_AUTO_RESUME 16'hf604
`define SRL_IDX_LOCK_LOST 16'hf605
`define SRL_IDX_RX_RATE 16'hf606
`define SRL_IDX_TX_RATE 16'hf607
`define SRL_IDX_SIDE_CTRL 16'hf608

// ----------------------------------------
// field positions
// ----------------------------------------
`define SRL_BIT_AUTO_RESUME 0
`define SRL_BIT_LOCK_LOST 0
`define SRL_BIT_HALF_RATE 0
`define SRL_SEL_MSB 3
`define SRL_SEL_LSB 0
`define SRL_BIT_CLK_SRC 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define SRL_RST_AUTO_RESUME 1'b0
`define SRL_RST_RX_HALF 1'b1
`define SRL_RST_TX_HALF 1'b1
`define SRL_RST_SEL 4'h0
`define SRL_RST_CLK_SRC 1'b0

// ----------------------------------------
// side stream frame
// ----------------------------------------
`define SRL_SLOTS 8
`define SRL_SLOT_W 32
`define SRL_FRAME_W 256
`define SRL_AUDIO_W 24
`define SRL_CNT_W 8

`endif

// File: hw/srl_half_en.sv
// clock enable divider: every cycle at full rate, every other cycle at half rate
`timescale 1ns/1ps
`include "srl_defs.svh"
module srl_half_en
    import srl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic half,
    output logic en
);
    logic phase_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            phase_r <= 1'b0;
        else
            phase_r <= ~phase_r;
    end

    assign en = ~half | phase_r;
endmodule

// File: hw/srl_lock_recovery.sv
// receiver lock recovery, clock rate selection and side stream output with avalon registers
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "srl_defs.svh"
module srl_lock_recovery
    import srl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_lock,
    input wire logic rx_sample_stb,
    input wire logic [23:0] rx_left,
    input wire logic [23:0] rx_right,
    input wire logic [3:0] rx_left_aux,
    input wire logic [3:0] rx_right_aux,
    input wire logic rx_compr_type,
    input wire logic rx_audio_type,
    input wire logic rx_block_start,
    input wire logic side_bit_en,
    output logic rx_mute,
    output logic rx_audio_stb,
    output logic [23:0] rx_audio_left,
    output logic [23:0] rx_audio_right,
    output logic receiver_clock_half_rate,
    output logic transmitter_clock_half_rate,
    output logic rx_mclk_en,
    output logic tx_mclk_en,
    output logic [3:0] serial_data_output_pin,
    output logic side_frame_sync,
    output logic side_stream_clock_source
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic sel_valid(input logic [3:0] s);
        sel_valid = (s == 4'h1) || (s == 4'h2) || (s == 4'h4) || (s == 4'h8);
    endfunction

    logic ack_r;
    logic [31:0] readdata_r;
    logic [15:0] idx;
    logic wr_acc;
    logic lane0_wr;
    logic auto_resume_r;
    logic rx_half_r;
    logic tx_half_r;
    logic [3:0] side_stream_port_select_r;
    logic side_clk_src_r;
    logic lock_lost_sticky_flag_r;
    logic restart_pend_r;
    srl_rx_state_t state_r;
    srl_rx_state_t state_nxt;
    logic lost_evt;
    logic resume_evt;
    logic auto_wr1;
    logic stb_r;
    logic [23:0] left_r;
    logic [23:0] right_r;
    logic [3:0] pin_r;
    logic sync_r;
    logic ser_data;
    logic ser_sync;
    logic side_en;

    // ----------------------------------------
    // avalon slave: one wait state per access
    // ----------------------------------------
    assign idx = avs_address[17:2];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_acc = avs_write & ack_r;
    assign lane0_wr = wr_acc & avs_byteenable[0];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    // unmapped indices read zero, writes to them are dropped
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            readdata_r <= 32'h0000_0000;
        else if (avs_read && !ack_r)
        begin
            case (idx)
                `SRL_IDX_AUTO_RESUME: readdata_r <= {31'h0000_0000, auto_resume_r};
                `SRL_IDX_LOCK_LOST: readdata_r <= {31'h0000_0000, lock_lost_sticky_flag_r};
                `SRL_IDX_RX_RATE: readdata_r <= {31'h0000_0000, rx_half_r};
                `SRL_IDX_TX_RATE: readdata_r <= {31'h0000_0000, tx_half_r};
                `SRL_IDX_SIDE_CTRL: readdata_r <= {27'h000_0000, side_clk_src_r, side_stream_port_select_r};
                default: readdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = readdata_r;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            auto_resume_r <= `SRL_RST_AUTO_RESUME;
            rx_half_r <= `SRL_RST_RX_HALF;
            tx_half_r <= `SRL_RST_TX_HALF;
            side_stream_port_select_r <= `SRL_RST_SEL;
            side_clk_src_r <= `SRL_RST_CLK_SRC;
        end
        else if (lane0_wr)
        begin
            case (idx)
                `SRL_IDX_AUTO_RESUME: auto_resume_r <= avs_writedata[`SRL_BIT_AUTO_RESUME];
                `SRL_IDX_RX_RATE: rx_half_r <= avs_writedata[`SRL_BIT_HALF_RATE];
                `SRL_IDX_TX_RATE: tx_half_r <= avs_writedata[`SRL_BIT_HALF_RATE];
                `SRL_IDX_SIDE_CTRL:
                begin
                    side_stream_port_select_r <= avs_writedata[`SRL_SEL_MSB:`SRL_SEL_LSB];
                    side_clk_src_r <= avs_writedata[`SRL_BIT_CLK_SRC];
                end
                default: auto_resume_r <= auto_resume_r;
            endcase
        end
    end

    assign auto_wr1 = lane0_wr && (idx == `SRL_IDX_AUTO_RESUME) && avs_writedata[`SRL_BIT_AUTO_RESUME];

    // ----------------------------------------
    // lock tracking
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SRL_ST_ACQUIRE:
                if (rx_lock && rx_sample_stb)
                    state_nxt = SRL_ST_PLAY;
            SRL_ST_PLAY:
                if (!rx_lock)
                    state_nxt = SRL_ST_MUTED;
            SRL_ST_MUTED:
                if (rx_lock && rx_sample_stb && (auto_resume_r || restart_pend_r))
                    state_nxt = SRL_ST_PLAY;
            default: state_nxt = SRL_ST_ACQUIRE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_r <= SRL_ST_ACQUIRE;
        else
            state_r <= state_nxt;
    end

    assign lost_evt = (state_r == SRL_ST_PLAY) && !rx_lock;
    assign resume_evt = (state_r == SRL_ST_MUTED) && (state_nxt == SRL_ST_PLAY);

    // manual restart: a 0 to 1 write is remembered until relock
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            restart_pend_r <= 1'b0;
        else if (auto_wr1 && !auto_resume_r && state_r == SRL_ST_MUTED)
            restart_pend_r <= 1'b1;
        else if (state_r != SRL_ST_MUTED)
            restart_pend_r <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            lock_lost_sticky_flag_r <= 1'b0;
        else if (lost_evt)
            lock_lost_sticky_flag_r <= 1'b1;
        else if (auto_wr1 || (resume_evt && auto_resume_r))
            lock_lost_sticky_flag_r <= 1'b0;
    end

    // mute rises on loss of the lock input without waiting a cycle, and clears only once the state is back in play
    assign rx_mute = (state_r != SRL_ST_PLAY) | ~rx_lock;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stb_r <= 1'b0;
            left_r <= 24'h00_0000;
            right_r <= 24'h00_0000;
        end
        else
        begin
            stb_r <= rx_sample_stb && (state_nxt == SRL_ST_PLAY);
            if (rx_sample_stb && state_nxt == SRL_ST_PLAY)
            begin
                left_r <= rx_left;
                right_r <= rx_right;
            end
        end
    end

    assign rx_audio_stb = stb_r;
    assign rx_audio_left = left_r;
    assign rx_audio_right = right_r;

    // ----------------------------------------
    // core clock rates
    // ----------------------------------------
    // receiver rate
    srl_half_en u_rx_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .half(rx_half_r),
        .en(rx_mclk_en)
    );

    srl_half_en u_tx_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .half(tx_half_r),
        .en(tx_mclk_en)
    );

    assign receiver_clock_half_rate = rx_half_r;
    assign transmitter_clock_half_rate = tx_half_r;

    // ----------------------------------------
    // side stream
    // ----------------------------------------
    // stream runs only with a legal port chosen
    assign side_en = sel_valid(side_stream_port_select_r);

    // audio slots of samples taken while muted carry zeros so no corrupted samples leak out
    srl_tdm_ser u_ser (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(side_en),
        .bit_en(side_bit_en),
        .snap_stb(rx_sample_stb),
        .left_audio(rx_mute ? 24'h00_0000 : rx_left),
        .right_audio(rx_mute ? 24'h00_0000 : rx_right),
        .left_aux(rx_left_aux),
        .right_aux(rx_right_aux),
        .compr_type(rx_compr_type),
        .audio_type(rx_audio_type),
        .block_start(rx_block_start),
        .sdata(ser_data),
        .frame_sync(ser_sync)
    );

    // one-hot routing, anything else stays silent
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_r <= 4'h0;
            sync_r <= 1'b0;
        end
        else
        begin
            pin_r <= side_en ? (side_stream_port_select_r & {4{ser_data}}) : 4'h0;
            sync_r <= ser_sync & side_en;
        end
    end

    assign serial_data_output_pin = pin_r;
    assign side_frame_sync = sync_r;
    // clock source choice handed to the serial port
    assign side_stream_clock_source = side_clk_src_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_MUTE_ON_LOSS: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == SRL_ST_PLAY && !rx_lock |-> rx_mute ##1 state_r == SRL_ST_MUTED)
        else $error("no mute on lock loss");
    AST_NO_SELF_RESUME: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == SRL_ST_MUTED && !auto_resume_r && !restart_pend_r |=> state_r != SRL_ST_PLAY)
        else $error("resumed without permission");
    AST_AUTO_RESUME: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == SRL_ST_MUTED && auto_resume_r && rx_lock && rx_sample_stb
        |=> state_r == SRL_ST_PLAY && !lock_lost_sticky_flag_r && rx_audio_stb)
        else $error("auto resume failed");
    AST_STICKY_SET: assert property (@(posedge clk_sys) disable iff (rst)
        lost_evt |=> lock_lost_sticky_flag_r)
        else $error("lost flag not set");
    AST_STICKY_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        lock_lost_sticky_flag_r && !auto_wr1 && !(resume_evt && auto_resume_r) |=> lock_lost_sticky_flag_r)
        else $error("lost flag dropped early");
    AST_RX_HALF: assert property (@(posedge clk_sys) disable iff (rst)
        (!rx_half_r |-> rx_mclk_en) and (rx_half_r && rx_mclk_en ##1 rx_half_r |-> !rx_mclk_en))
        else $error("receiver clock rate wrong");
    AST_TX_HALF: assert property (@(posedge clk_sys) disable iff (rst)
        (!tx_half_r |-> tx_mclk_en) and (tx_half_r && tx_mclk_en ##1 tx_half_r |-> !tx_mclk_en))
        else $error("transmitter clock rate wrong");
    AST_PORT_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
        ((pin_r & ~$past(side_stream_port_select_r)) == 4'h0)
        && !(side_frame_sync && !$past(side_en)))
        else $error("stream on unselected pin");
endmodule

// File: hw/srl_pkg.sv
// types shared by the lock recovery block
package srl_pkg;
    typedef enum logic [1:0]
    {
        SRL_ST_ACQUIRE,
        SRL_ST_PLAY,
        SRL_ST_MUTED
    } srl_rx_state_t;
endpackage

// File: hw/srl_tdm_ser.sv
// eight slot side stream serializer, msb first
`timescale 1ns/1ps
`include "srl_defs.svh"
module srl_tdm_ser
    import srl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    input wire logic bit_en,
    input wire logic snap_stb,
    input wire logic [23:0] left_audio,
    input wire logic [23:0] right_audio,
    input wire logic [3:0] left_aux,
    input wire logic [3:0] right_aux,
    input wire logic compr_type,
    input wire logic audio_type,
    input wire logic block_start,
    output logic sdata,
    output logic frame_sync
);
    // ----------------------------------------
    // frame layout
    // ----------------------------------------
    function automatic logic [255:0] build_frame(
        input logic [23:0] l,
        input logic [23:0] r,
        input logic [3:0] la,
        input logic [3:0] ra,
        input logic ct,
        input logic at,
        input logic bs);
        build_frame = {l, 8'h00,
                       20'h0_0000, la, 8'h00,
                       22'h00_0000, ct, at, 8'h00,
                       32'h0000_0000,
                       r, 8'h00,
                       20'h0_0000, ra, 8'h00,
                       32'h0000_0000,
                       23'h00_0000, bs, 8'h00};
    endfunction

    logic [255:0] snap_r;
    logic [255:0] shift_r;
    logic [7:0] cnt_r;
    logic sdata_r;
    logic sync_r;

    // snapshot taken per sample, used at next frame start so a frame never tears
    // slot contents
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            snap_r <= '0;
        else if (snap_stb)
            snap_r <= build_frame(left_audio, right_audio, left_aux, right_aux,
                                  compr_type, audio_type, block_start);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            shift_r <= '0;
            cnt_r <= 8'h00;
            sdata_r <= 1'b0;
        end
        else if (!enable)
        begin
            shift_r <= '0;
            cnt_r <= 8'h00;
            sdata_r <= 1'b0;
        end
        else if (bit_en)
        begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == 8'h00)
            begin
                sdata_r <= snap_r[255];
                shift_r <= {snap_r[254:0], 1'b0};
            end
            else
            begin
                sdata_r <= shift_r[255];
                shift_r <= {shift_r[254:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            sync_r <= 1'b0;
        else
            sync_r <= enable & bit_en & (cnt_r == 8'h00);
    end

    assign sdata = sdata_r;
    assign frame_sync = sync_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_FRAME_LEN: assert property (@(posedge clk_sys) disable iff (rst)
        sync_r |-> cnt_r == 8'h01)
        else $error("frame sync not at first bit of 256");
    AST_FRAME_ZEROS: assert property (@(posedge clk_sys) disable iff (rst)
        snap_stb |=> snap_r[231:224] == 8'h00 && snap_r[223:204] == 20'h0_0000
            && snap_r[191:170] == 22'h00_0000 && snap_r[159:128] == 32'h0000_0000
            && snap_r[31:9] == 23'h00_0000 && snap_r[7:0] == 8'h00)
        else $error("zero fields of frame not zero");
    AST_SLOT0_AUDIO: assert property (@(posedge clk_sys) disable iff (rst)
        snap_stb |=> snap_r[255:232] == $past(left_audio) && snap_r[127:104] == $past(right_audio))
        else $error("audio not in slots 0 and 4");
endmodule
